// ---- bfd_decoder.sv ----
// Binary input function decoder: qualifies inputs and turns them into commands.
`timescale 1ns/1ns
`include "bfd_map.svh"

// Overview of operation
// - Fault and maintenance inputs active at 0 V in fail-safe mode, else 24 V.
// - Function-control inputs use fault polarity and drive the function-control flag.
// - Qualified acknowledge pulse clears all logbook entries.
// - Faults or maintenance requests still present are re-entered after acknowledge.
// - Autocal pulse starts autocal only when measuring and autocal configured.
// - Range pulse selects the matching measuring range one to four.
// - Zero-gas pulse while measuring opens zero valve and enters calibrating.
// - Calibration-gas pulse while measuring opens its valve and enters calibrating.
// - Sample-gas pulse accepted measuring or calibrating; pump variant also from standby.
// - Sample gas closes all other valves first, then opens the sample valve.
// - Once the sample valve opens the device is measuring.
// - Zero or span calibration pulse starts that calibration.
// - Auto-range pulse enables automatic range switching.
// - Calibration-check pulse starts the check only while measuring.
// - Measurement protection at 24 V keeps a measuring device measuring while no function-control input is active.
// - Protection refuses zero-gas and calibration-gas pulses and state commands, clears decode_ok_o and remote_ok_o and flags itself.
// - Standby pulse selects standby start-up, pump variant only.
// - An unassigned input has no effect at any level.
// - Fail-safe mode selects inverted level polarity, otherwise legacy polarity.
// - A function may be mapped to one input only; duplicates are rejected.
// - Six standard inputs plus eight more when the option board is fitted.
module bfd_decoder #(
	parameter int N_IN         = `BFD_STD_INPUTS + `BFD_OPT_INPUTS,
	parameter int QUAL_CYCLES  = `BFD_QUAL_CYCLES,
	parameter int PRESS_CYCLES = `BFD_PRESS_CYCLES,
	parameter int CW           = 24
) (
	input  wire logic              clock_i,
	input  wire logic              nrst_i,
	input  wire logic [N_IN-1:0]   bin_i,
	input  wire logic [4:0]        addr_i,
	input  wire logic [7:0]        wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [7:0]        rdata_o,
	output logic                   zero_valve_o,
	output logic                   cal_valve_o,
	output logic                   sample_valve_o,
	output logic      [6:0]        fault_o,
	output logic      [6:0]        maint_o,
	output logic                   func_ctrl_o,
	output logic                   mprot_o,
	output logic                   decode_ok_o,
	output logic                   remote_ok_o,
	output logic                   log_clear_o,
	output logic                   log_relog_o,
	output logic                   autocal_start_o,
	output logic                   check_start_o,
	output logic                   zero_cal_start_o,
	output logic                   span_cal_start_o,
	output logic      [1:0]        range_o,
	output logic                   autorange_o,
	output logic                   standby_startup_o,
	output bfd_pkg::bfd_state_t    state_o
);
	import bfd_pkg::*;

	typedef struct packed {
		logic [N_IN-1:0]           s1;
		logic [N_IN-1:0]           s2;
		logic [N_IN-1:0]           s3;
		logic [N_IN-1:0]           lvl;
		logic [N_IN-1:0]           done;
		logic [N_IN-1:0][CW-1:0]   cnt;
		logic [N_IN-1:0][5:0]      map;
		logic [3:0]                ctrl;
		bfd_state_t                st;
		bfd_seq_t                  seq;
		logic [CW-1:0]             pcnt;
		logic [1:0]                range;
		logic                      autor;
		logic                      sbup;
		logic                      zero_v;
		logic                      cal_v;
		logic                      samp_v;
		logic [6:0]                fault;
		logic [6:0]                maint;
		logic                      fc;
		logic                      mprot;
		logic                      clr;
		logic                      relog;
		logic                      acal;
		logic                      chk;
		logic                      zcal;
		logic                      scal;
		logic                      rej;
		logic                      ok;
		logic [7:0]                rdata;
	} bfd_reg_t;

	bfd_reg_t         q;
	bfd_reg_t         n;
	logic [N_IN-1:0]  en;
	logic [N_IN-1:0]  pul;
	logic [63:0]      am;
	logic [63:0]      hi;
	logic [63:0]      pf;
	logic             fsp;
	logic             fcl;
	logic             sacc;
	logic             zacc;
	logic             cacc;
	logic             dup;
	logic [3:0]       widx;

	assign fsp  = q.ctrl[`BFD_CTRL_FSP];
	assign widx = addr_i[3:0];

	// Option-board inputs stay inert until the board is declared fitted.
	genvar gi;
	generate
		for (gi = 0; gi < N_IN; gi++) begin : g_in
			assign en[gi]  = (gi < `BFD_STD_INPUTS) || q.ctrl[`BFD_CTRL_OPT];
			assign pul[gi] = q.lvl[gi] && !q.done[gi]
				&& (q.cnt[gi] == CW'(QUAL_CYCLES - 1));
		end
	endgenerate

	// Code zero collects unassigned inputs and is never read below.
	always_comb begin
		am = '0;
		hi = '0;
		pf = '0;
		for (int i = 0; i < N_IN; i++) begin
			if (en[i]) begin
				am[q.map[i]] = 1'b1;
				hi[q.map[i]] = hi[q.map[i]] | q.lvl[i];
				pf[q.map[i]] = pf[q.map[i]] | pul[i];
			end
		end
	end

	always_comb begin
		fcl = 1'b0;
		for (int k = 0; k < 4; k++) begin
			fcl = fcl | (am[`BFD_FN_FC + k] & (hi[`BFD_FN_FC + k] ^ fsp));
		end
	end

	always_comb begin
		dup = 1'b0;
		for (int j = 0; j < N_IN; j++) begin
			if ((j != int'(widx)) && (q.map[j] == wdata_i[5:0])) begin
				dup = 1'b1;
			end
		end
		dup = dup && (wdata_i[5:0] != `BFD_FN_NONE);
	end

	assign sacc = pf[`BFD_FN_SGAS] && (q.seq == BFD_SQ_IDLE)
		&& ((q.st == BFD_ST_MEAS) || (q.st == BFD_ST_CAL)
		|| ((q.st == BFD_ST_STBY) && q.ctrl[`BFD_CTRL_PUMP]));
	assign zacc = pf[`BFD_FN_ZGAS] && (q.st == BFD_ST_MEAS)
		&& (q.seq == BFD_SQ_IDLE) && !q.mprot;
	assign cacc = pf[`BFD_FN_CGAS] && (q.st == BFD_ST_MEAS)
		&& (q.seq == BFD_SQ_IDLE) && !q.zero_v && !q.mprot;

	always_comb begin
		n = q;
		n.s1 = bin_i;
		n.s2 = q.s1;
		n.s3 = q.s2;
		// A level change counts only once the two later stages agree.
		for (int i = 0; i < N_IN; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				n.lvl[i] = q.s3[i];
			end
			if (!q.lvl[i]) begin
				n.cnt[i]  = '0;
				n.done[i] = 1'b0;
			end else if (pul[i]) begin
				n.done[i] = 1'b1;
			end else if (!q.done[i]) begin
				n.cnt[i] = q.cnt[i] + CW'(1);
			end
		end
		for (int k = 0; k < 7; k++) begin
			n.fault[k] = am[`BFD_FN_FAULT + k] & (hi[`BFD_FN_FAULT + k] ^ fsp);
			n.maint[k] = am[`BFD_FN_MAINT + k] & (hi[`BFD_FN_MAINT + k] ^ fsp);
		end
		n.fc    = fcl || (q.st == BFD_ST_CAL);
		n.clr   = pf[`BFD_FN_ACK];
		n.relog = q.clr && ((|q.fault) || (|q.maint));
		n.acal  = pf[`BFD_FN_ACAL] && (q.st == BFD_ST_MEAS)
			&& q.ctrl[`BFD_CTRL_ACAL];
		n.chk   = pf[`BFD_FN_CHK] && (q.st == BFD_ST_MEAS);
		n.zcal  = pf[`BFD_FN_ZCAL];
		n.scal  = pf[`BFD_FN_SCAL];
		for (int k = 0; k < 4; k++) begin
			if (pf[`BFD_FN_RANGE + k]) begin
				n.range = 2'(k);
				n.autor = 1'b0;
			end
		end
		if (pf[`BFD_FN_AUTOR]) begin
			n.autor = 1'b1;
		end
		if (pf[`BFD_FN_STBY] && q.ctrl[`BFD_CTRL_PUMP]) begin
			n.sbup = 1'b1;
		end
		// A zero or span calibration pulse while calibrating returns the gas path to sample.
		if ((pf[`BFD_FN_ZCAL] || pf[`BFD_FN_SCAL]) && (q.st == BFD_ST_CAL)
			&& (q.seq == BFD_SQ_IDLE)) begin
			n.seq    = BFD_SQ_CLOSE;
			n.zero_v = 1'b0;
			n.cal_v  = 1'b0;
		end
		if (zacc) begin
			n.zero_v = 1'b1;
			n.cal_v  = 1'b0;
			n.samp_v = 1'b0;
			n.st     = BFD_ST_CAL;
		end else if (cacc) begin
			n.cal_v  = 1'b1;
			n.samp_v = 1'b0;
			n.st     = BFD_ST_CAL;
		end
		case (q.seq)
			BFD_SQ_IDLE: begin
				if (sacc) begin
					n.seq = BFD_SQ_CLOSE;
				end
			end
			BFD_SQ_CLOSE: begin
				n.zero_v = 1'b0;
				n.cal_v  = 1'b0;
				n.samp_v = 1'b0;
				n.pcnt   = '0;
				n.seq    = (q.st == BFD_ST_STBY) ? BFD_SQ_WAIT : BFD_SQ_OPEN;
			end
			BFD_SQ_WAIT: begin
				n.pcnt = q.pcnt + CW'(1);
				if (q.pcnt == CW'(PRESS_CYCLES - 1)) begin
					n.seq = BFD_SQ_OPEN;
				end
			end
			BFD_SQ_OPEN: begin
				n.samp_v = 1'b1;
				n.st     = BFD_ST_MEAS;
				n.seq    = BFD_SQ_IDLE;
			end
			default: begin
				n.seq = BFD_SQ_IDLE;
			end
		endcase
		n.rdata = 8'h00;
		if (rd_i) begin
			case (addr_i)
				`BFD_ADDR_CTRL:  n.rdata = {4'h0, q.ctrl};
				`BFD_ADDR_STAT:  n.rdata = {q.mprot, q.fc, q.rej, q.autor,
					q.range, q.st};
				`BFD_ADDR_FAULT: n.rdata = {1'b0, q.fault};
				`BFD_ADDR_MAINT: n.rdata = {1'b0, q.maint};
				default: begin
					if (addr_i[4] && (int'(widx) < N_IN)) begin
						n.rdata = {2'h0, q.map[widx]};
					end
				end
			endcase
		end
		if (wr_i) begin
			if (addr_i == `BFD_ADDR_CTRL) begin
				n.ctrl = wdata_i[3:0];
			// A zero-gas or calibration-gas pulse taken in the same cycle outranks a state command.
			end else if ((addr_i == `BFD_ADDR_CMD) && !q.mprot
				&& (q.seq == BFD_SQ_IDLE) && !zacc && !cacc) begin
				if (wdata_i[1:0] == `BFD_CMD_STBY) begin
					n.st     = BFD_ST_STBY;
					n.samp_v = 1'b0;
					n.zero_v = 1'b0;
					n.cal_v  = 1'b0;
				end else if (wdata_i[1:0] == `BFD_CMD_MEAS) begin
					n.seq = BFD_SQ_CLOSE;
				end
			end else if (addr_i[4] && (int'(widx) < N_IN)) begin
				n.rej = dup;
				if (!dup) begin
					n.map[widx] = wdata_i[5:0];
				end
			end
		end
		// Protection is judged on the state being entered, so it never outlives measuring.
		n.mprot = am[`BFD_FN_MPROT] && hi[`BFD_FN_MPROT]
			&& (n.st == BFD_ST_MEAS) && !fcl;
		n.ok    = !n.mprot;
	end

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			q    <= '0;
			q.ok <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign rdata_o           = q.rdata;
	assign zero_valve_o      = q.zero_v;
	assign cal_valve_o       = q.cal_v;
	assign sample_valve_o    = q.samp_v;
	assign fault_o           = q.fault;
	assign maint_o           = q.maint;
	assign func_ctrl_o       = q.fc;
	assign mprot_o           = q.mprot;
	assign decode_ok_o       = q.ok;
	assign remote_ok_o       = q.ok;
	assign log_clear_o       = q.clr;
	assign log_relog_o       = q.relog;
	assign autocal_start_o   = q.acal;
	assign check_start_o     = q.chk;
	assign zero_cal_start_o  = q.zcal;
	assign span_cal_start_o  = q.scal;
	assign range_o           = q.range;
	assign autorange_o       = q.autor;
	assign standby_startup_o = q.sbup;
	assign state_o           = q.st;

	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);

	sequence s_sample_taken;
		sacc;
	endsequence
	sequence s_all_closed;
		(q.seq == BFD_SQ_CLOSE) ##1 (!q.zero_v && !q.cal_v && !q.samp_v);
	endsequence

	chk_sample_close_first: assert property (s_sample_taken |=> s_all_closed)
		else $error("Sample gas did not close the other valves first.");
	chk_sample_to_meas: assert property ($rose(q.samp_v) |-> q.st == BFD_ST_MEAS
		&& $past(q.seq) == BFD_SQ_OPEN)
		else $error("Sample valve opened outside the measuring hand-over.");
	chk_zero_gas_cal: assert property (zacc |=> q.zero_v && !q.samp_v
		&& q.st == BFD_ST_CAL)
		else $error("Zero gas pulse did not enter calibrating.");
	chk_cal_gas_cal: assert property (cacc |=> q.cal_v && q.st == BFD_ST_CAL)
		else $error("Calibration gas pulse did not enter calibrating.");
	chk_relog_after_ack: assert property (q.clr && (|q.fault) |=> q.relog)
		else $error("Present fault not re-entered after acknowledge.");
	chk_ack_clears_log: assert property (pf[`BFD_FN_ACK] |=> q.clr ##1 !q.clr)
		else $error("Acknowledge did not give one clear pulse.");
	chk_autocal_gate: assert property (q.acal |-> $past(q.st) == BFD_ST_MEAS
		&& $past(q.ctrl[`BFD_CTRL_ACAL]))
		else $error("Autocal started outside measuring or unconfigured.");
	chk_mprot_holds: assert property (q.mprot && !zacc |=> q.st == BFD_ST_MEAS)
		else $error("Protected measuring state was left.");
	chk_mprot_refuse: assert property (q.mprot |-> !remote_ok_o && q.st == BFD_ST_MEAS)
		else $error("Remote operation allowed under protection.");
	chk_pulse_once: assert property (pul[0] |=> !pul[0] [*8])
		else $error("Qualified pulse acted twice.");
	chk_range_select: assert property (pf[`BFD_FN_RANGE + 2] && !pf[`BFD_FN_RANGE + 3]
		|=> q.range == 2'h2)
		else $error("Range three pulse did not select range three.");
	chk_fault_polarity: assert property (am[`BFD_FN_FAULT] |=>
		q.fault[0] == ($past(hi[`BFD_FN_FAULT]) ^ $past(fsp)))
		else $error("Fault one did not follow the selected polarity.");
	chk_check_gate: assert property (q.chk |-> $past(q.st) == BFD_ST_MEAS)
		else $error("Calibration check started outside measuring.");
	chk_standby_pump: assert property (!q.ctrl[`BFD_CTRL_PUMP] && !q.sbup |=> !q.sbup)
		else $error("Standby start-up chosen without the pump variant.");
	chk_sample_refused: assert property (pf[`BFD_FN_SGAS] && (q.st == BFD_ST_STBY)
		&& (q.seq == BFD_SQ_IDLE) && !q.ctrl[`BFD_CTRL_PUMP] && !wr_i |=> q.seq == BFD_SQ_IDLE)
		else $error("Sample gas taken from standby without the pump variant.");
	chk_autorange_on: assert property (pf[`BFD_FN_AUTOR] |=> q.autor)
		else $error("Auto-range pulse did not enable range switching.");
endmodule

// ---- bfd_map.svh ----
// Register offsets, field positions, function codes and timing counts.
`ifndef BFD_MAP_SVH
`define BFD_MAP_SVH
`define BFD_CLK_PERIOD_NS  100
`define BFD_QUAL_TIME_MS   1000
`define BFD_PRESS_TIME_MS  200
`define BFD_QUAL_CYCLES    (`BFD_QUAL_TIME_MS * 1000000 / `BFD_CLK_PERIOD_NS)
`define BFD_PRESS_CYCLES   (`BFD_PRESS_TIME_MS * 1000000 / `BFD_CLK_PERIOD_NS)
`define BFD_STD_INPUTS     6
`define BFD_OPT_INPUTS     8
`define BFD_ADDR_CTRL      5'h00
`define BFD_ADDR_CMD       5'h01
`define BFD_ADDR_STAT      5'h02
`define BFD_ADDR_FAULT     5'h03
`define BFD_ADDR_MAINT     5'h04
`define BFD_ADDR_MAP       5'h10
`define BFD_CTRL_FSP       0
`define BFD_CTRL_ACAL      1
`define BFD_CTRL_PUMP      2
`define BFD_CTRL_OPT       3
`define BFD_CTRL_RST       4'h0
`define BFD_CMD_MEAS       2'h1
`define BFD_CMD_STBY       2'h2
`define BFD_FN_NONE        6'h00
`define BFD_FN_FAULT       6'h01
`define BFD_FN_MAINT       6'h08
`define BFD_FN_ACK         6'h0F
`define BFD_FN_FC          6'h10
`define BFD_FN_ACAL        6'h14
`define BFD_FN_RANGE       6'h15
`define BFD_FN_ZGAS        6'h19
`define BFD_FN_CGAS        6'h1A
`define BFD_FN_SGAS        6'h1B
`define BFD_FN_ZCAL        6'h1C
`define BFD_FN_SCAL        6'h1D
`define BFD_FN_AUTOR       6'h1E
`define BFD_FN_CHK         6'h1F
`define BFD_FN_MPROT       6'h20
`define BFD_FN_STBY        6'h21
`endif

// ---- bfd_pkg.sv ----
// Types shared by the binary input function decoder.
package bfd_pkg;
	typedef enum logic [1:0] {
		BFD_ST_MEAS,
		BFD_ST_CAL,
		BFD_ST_STBY
	} bfd_state_t;
	typedef enum logic [1:0] {
		BFD_SQ_IDLE,
		BFD_SQ_CLOSE,
		BFD_SQ_WAIT,
		BFD_SQ_OPEN
	} bfd_seq_t;
endpackage

// ---- bfd_contacts.sv ----
// Model of the outside contacts that drive the binary inputs.
`timescale 1ns/1ns
module bfd_contacts #(
	parameter int N = 14
) (
	input  wire logic         clock_i,
	output logic      [N-1:0] bin_o
);
	initial bin_o = '0;

	// Contacts switch only just after an edge, so no change lands on a sampling instant.
	task automatic set_lvl(input int ch, input logic v);
		@(posedge clock_i);
		bin_o[ch] <= v;
	endtask

	// The contact stays at 24 V for the whole requested time and only then lets go.
	task automatic pulse(input int ch, input int len);
		set_lvl(ch, 1'b1);
		repeat (len) @(posedge clock_i);
		bin_o[ch] <= 1'b0;
	endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the binary input function decoder.
`timescale 1ns/1ns
`include "bfd_map.svh"
module tb_top;
	import bfd_pkg::*;
	localparam int Q = 20;
	localparam int P = 5;
	logic        clock_i = 1'b0;
	logic        nrst_i  = 1'b0;
	logic [4:0]  addr_i  = 5'h00;
	logic [7:0]  wdata_i = 8'h00;
	logic        wr_i    = 1'b0;
	logic        rd_i    = 1'b0;
	logic [7:0]  ctrl    = 8'h00;
	wire  [13:0] bin;
	logic [7:0]  rdata_o;
	logic [6:0]  fault_o, maint_o;
	logic [1:0]  range_o;
	logic        zero_valve_o, cal_valve_o, sample_valve_o, func_ctrl_o, mprot_o;
	logic        decode_ok_o, remote_ok_o, log_clear_o, log_relog_o, autocal_start_o;
	logic        check_start_o, zero_cal_start_o, span_cal_start_o, autorange_o;
	logic        standby_startup_o, sv_q = 1'b0, zv_q = 1'b0, cv_q = 1'b0;
	bfd_state_t  state_o;
	int          miscompares = 0, checks_done = 0, seed = 16799;
	int          n_clr = 0, n_rel = 0, n_acal = 0, n_chk = 0, n_zc = 0, n_sc = 0;
	logic [5:0]  fn [14] = '{6'h0F, 6'h01, 6'h08, 6'h10, 6'h14, 6'h21, 6'h17,
		6'h19, 6'h1A, 6'h1B, 6'h1C, 6'h1D, 6'h1E, 6'h1F};

	always #50 clock_i = ~clock_i;

	bfd_contacts cts (.clock_i(clock_i), .bin_o(bin));

	bfd_decoder #(.QUAL_CYCLES(Q), .PRESS_CYCLES(P)) DUT (.clock_i, .nrst_i, .bin_i(bin),
		.addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .zero_valve_o, .cal_valve_o,
		.sample_valve_o, .fault_o, .maint_o, .func_ctrl_o, .mprot_o, .decode_ok_o,
		.remote_ok_o, .log_clear_o, .log_relog_o, .autocal_start_o, .check_start_o,
		.zero_cal_start_o, .span_cal_start_o, .range_o, .autorange_o,
		.standby_startup_o, .state_o);

	// Pulses are counted mid-cycle, away from the edge that launches them.
	always @(negedge clock_i) begin
		n_clr += (log_clear_o === 1'b1);
		n_rel += (log_relog_o === 1'b1);
		n_acal += (autocal_start_o === 1'b1);
		n_chk += (check_start_o === 1'b1);
		n_zc += (zero_cal_start_o === 1'b1);
		n_sc += (span_cal_start_o === 1'b1);
		if (sample_valve_o === 1'b1 && sv_q !== 1'b1) begin
			chk({6'h00, zv_q, cv_q}, 8'h00);
		end
		sv_q = sample_valve_o;
		zv_q = zero_valve_o;
		cv_q = cal_valve_o;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chkb(input logic got, input logic exp);
		chk({7'h00, got}, {7'h00, exp});
	endtask

	task automatic cst(input bfd_state_t e);
		chk({6'h00, state_o}, {6'h00, e});
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask

	task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk(d, exp);
	endtask

	task automatic fire(input int ch);
		cts.pulse(ch, Q + 4);
		repeat (8) @(posedge clock_i);
		#1;
	endtask

	task automatic settle;
		repeat (8) @(posedge clock_i);
		#1;
	endtask

	// Bounded, so a sequence that never finishes cannot hang the run.
	task automatic wait_meas;
		int i;
		for (i = 0; i < 100 && !(state_o === BFD_ST_MEAS && sample_valve_o === 1'b1); i++) begin
			@(posedge clock_i);
			#1;
		end
		if (i == 100) begin
			miscompares++;
			summarize();
		end
	endtask

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		int i;
		int r;
		logic [7:0] d;
		repeat (6) @(posedge clock_i);
		nrst_i <= 1'b1;
		#1 cst(BFD_ST_MEAS);
		chkb(decode_ok_o, 1'b1);
		rdchk(`BFD_ADDR_CTRL, 8'h00);
		done("reset");
		ctrl[`BFD_CTRL_OPT] = 1'b1;
		wr(`BFD_ADDR_CTRL, ctrl);
		for (i = 0; i < 14; i++)
			wr(5'(`BFD_ADDR_MAP + i), {2'b00, fn[i]});
		rdchk(5'h19, 8'h1B);
		wr(5'h1D, 8'h0F);
		rdchk(5'h1D, 8'h1F);
		rd(`BFD_ADDR_STAT, d);
		chkb(d[5], 1'b1);
		rdchk(5'h08, 8'h00);
		@(posedge clock_i);
		#1 chk(rdata_o, 8'h00);
		done("map");
		ctrl[`BFD_CTRL_OPT] = 1'b0;
		wr(`BFD_ADDR_CTRL, ctrl);
		fire(6);
		chk(8'(range_o), 8'h00);
		ctrl[`BFD_CTRL_OPT] = 1'b1;
		wr(`BFD_ADDR_CTRL, ctrl);
		fire(6);
		chk(8'(range_o), 8'h02);
		fire(12);
		chkb(autorange_o, 1'b1);
		fire(6);
		chkb(autorange_o, 1'b0);
		done("range");
		for (i = 0; i < 8; i++) begin
			r = (i < 2) ? i : $random(seed);
			ctrl[`BFD_CTRL_FSP] = r[0];
			wr(`BFD_ADDR_CTRL, ctrl);
			cts.set_lvl(1, r[1]);
			cts.set_lvl(2, r[2]);
			cts.set_lvl(3, r[3]);
			settle();
			chk({1'b0, fault_o}, {7'h00, r[1] ^ r[0]});
			chk({1'b0, maint_o}, {7'h00, r[2] ^ r[0]});
			chkb(func_ctrl_o, r[3] ^ r[0]);
		end
		done("polarity");
		ctrl[`BFD_CTRL_FSP] = 1'b0;
		wr(`BFD_ADDR_CTRL, ctrl);
		cts.set_lvl(1, 1'b1);
		cts.set_lvl(2, 1'b0);
		cts.set_lvl(3, 1'b0);
		fire(0);
		chk(8'(n_clr), 8'h01);
		chk(8'(n_rel), 8'h01);
		cts.pulse(0, Q - 6);
		settle();
		chk(8'(n_clr), 8'h01);
		cts.set_lvl(1, 1'b0);
		done("acknowledge");
		fire(4);
		chk(8'(n_acal), 8'h00);
		ctrl[`BFD_CTRL_ACAL] = 1'b1;
		wr(`BFD_ADDR_CTRL, ctrl);
		fire(4);
		chk(8'(n_acal), 8'h01);
		fire(13);
		chk(8'(n_chk), 8'h01);
		done("autocal");
		fire(7);
		chkb(zero_valve_o, 1'b1);
		cst(BFD_ST_CAL);
		chkb(func_ctrl_o, 1'b1);
		fire(13);
		chk(8'(n_chk), 8'h01);
		fire(8);
		chkb(cal_valve_o, 1'b0);
		fire(10);
		chk(8'(n_zc), 8'h01);
		wait_meas();
		chkb(zero_valve_o, 1'b0);
		chkb(sample_valve_o, 1'b1);
		chkb(func_ctrl_o, 1'b0);
		fire(8);
		chkb(cal_valve_o, 1'b1);
		cst(BFD_ST_CAL);
		fire(9);
		wait_meas();
		chkb(cal_valve_o, 1'b0);
		fire(11);
		chk(8'(n_sc), 8'h01);
		done("gas");
		fire(5);
		chkb(standby_startup_o, 1'b0);
		ctrl[`BFD_CTRL_PUMP] = 1'b1;
		wr(`BFD_ADDR_CTRL, ctrl);
		fire(5);
		chkb(standby_startup_o, 1'b1);
		ctrl[`BFD_CTRL_PUMP] = 1'b0;
		wr(`BFD_ADDR_CTRL, ctrl);
		wr(`BFD_ADDR_CMD, {6'h00, `BFD_CMD_STBY});
		settle();
		cst(BFD_ST_STBY);
		fire(9);
		cst(BFD_ST_STBY);
		ctrl[`BFD_CTRL_PUMP] = 1'b1;
		wr(`BFD_ADDR_CTRL, ctrl);
		fire(9);
		wait_meas();
		wr(`BFD_ADDR_CMD, {6'h00, `BFD_CMD_STBY});
		settle();
		chkb(sample_valve_o, 1'b0);
		wr(`BFD_ADDR_CMD, {6'h00, `BFD_CMD_MEAS});
		wait_meas();
		cst(BFD_ST_MEAS);
		done("standby");
		wr(5'h14, 8'h00);
		fire(4);
		chk(8'(n_acal), 8'h01);
		wr(5'h1C, 8'h20);
		cts.set_lvl(12, 1'b1);
		settle();
		chkb(mprot_o, 1'b1);
		chkb(decode_ok_o, 1'b0);
		chkb(remote_ok_o, 1'b0);
		fire(7);
		cst(BFD_ST_MEAS);
		chkb(zero_valve_o, 1'b0);
		wr(`BFD_ADDR_CMD, {6'h00, `BFD_CMD_STBY});
		settle();
		cst(BFD_ST_MEAS);
		rd(`BFD_ADDR_STAT, d);
		chkb(d[7], 1'b1);
		cts.set_lvl(12, 1'b0);
		settle();
		chkb(mprot_o, 1'b0);
		chkb(remote_ok_o, 1'b1);
		done("protection");
		summarize();
	end
endmodule
